//--- design/processor_trap_unit.sv
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module processor_trap_unit #(
    parameter int NWINDOWS = 8
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Wishbone slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [7:0]                 wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    // Instruction about to begin
    input  wire trap_pkg::instr_info_t      instr_i,
    output logic                            instr_go_o,
    // Far-side events (from pins, synchronised here)
    input  wire logic [3:0]                 interrupt_request_level_i,
    input  wire logic                       float_trap_i,
    input  wire logic                       coproc_trap_i,
    input  wire logic                       mcheck_i,
    input  wire logic                       mcheck_second_access_i,
    // Trap results
    output trap_pkg::trap_out_t             trap_o,
    output logic                            error_mode_o
);
    import trap_pkg::*;

    initial begin
        if (NWINDOWS < 2 || NWINDOWS > (1 << NWIN_BITS)) begin
            $error("NWINDOWS out of range");
        end
    end

    // Two-flop synchronisers for the pin inputs
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= {interrupt_request_level_i, mcheck_second_access_i,
                          mcheck_i, coproc_trap_i, float_trap_i};
            sync2_reg <= sync1_reg;
        end
    end
    logic [3:0] irl;
    logic       fp_ev, cp_ev, mc_ev, mc2_ev;
    assign {irl, mc2_ev, mc_ev, cp_ev, fp_ev} = sync2_reg;

    // Architectural state
    logic [NWIN_BITS-1:0] cwp_reg, cwp_next;
    logic                 enable_reg, enable_next;
    logic [3:0]           thresh_reg, thresh_next;
    logic [19:0]          base_reg, base_next;
    logic [7:0]           type_reg, type_next;
    logic [XLEN-1:0]      pc_save_reg, pc_save_next;
    logic [XLEN-1:0]      next_pc_save_reg, next_pc_save_next;
    logic                 fp_pend_reg, fp_pend_next;
    logic                 cp_pend_reg, cp_pend_next;
    logic                 mc_pend_reg, mc_pend_next;
    logic                 unresumable_reg, unresumable_next;
    logic                 error_reg, error_next;
    logic [XLEN-1:0]      queue_head_reg, queue_head_next;
    logic                 ack_reg, ack_next;
    logic [31:0]          rdat_reg, rdat_next;
    trap_out_t            trap_reg, trap_next;

    logic wb_req;
    logic wb_wr;
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr  = wb_req && wb_we_i && (wb_sel_i == 4'hF);

    // Arbitration signals
    logic       irq_ok;
    logic       take;
    logic       precise_kind;
    logic [7:0] sel_type;
    logic [NWIN_BITS-1:0] cwp_dec;

    always_comb begin
        cwp_dec = (cwp_reg == '0) ? NWIN_BITS'(NWINDOWS - 1) : cwp_reg - 1'b1;
        // Interrupt above threshold or unmaskable level, only with enable set
        irq_ok  = enable_reg && (irl != 4'h0)
                  && ((irl > thresh_reg) || (irl == IRQ_UNMASKED));
        take         = 1'b0;
        precise_kind = 1'b0;
        sel_type     = 8'h00;
        // Fixed priority: machine check, provoked deferred, precise, soft, irq
        if (mc_pend_reg && (mc2_ev || instr_i.is_mc_probe || instr_i.valid)) begin
            take     = 1'b1;
            sel_type = TYPE_MCHECK;
        end else if (fp_pend_reg && instr_i.valid && instr_i.is_float) begin
            take     = 1'b1;
            sel_type = TYPE_FLOAT;
        end else if (cp_pend_reg && instr_i.valid && instr_i.is_coproc) begin
            take     = 1'b1;
            sel_type = TYPE_COPROC;
        end else if (instr_i.valid && instr_i.precise_exc) begin
            // Float and coproc pending may stay deferred past this trap
            take         = 1'b1;
            precise_kind = 1'b1;
            sel_type     = {1'b0, instr_i.precise_type[6:0]};
        end else if (instr_i.valid && instr_i.soft_trap) begin
            take         = 1'b1;
            precise_kind = 1'b1;
            sel_type = TYPE_SOFT_BASE | {1'b0, instr_i.soft_num & SOFT_MASK};
        end else if (irq_ok && instr_i.valid) begin
            // Only ahead of a real instruction, so the saved counters mean something
            take     = 1'b1;
            sel_type = TYPE_IRQ_BASE | {4'h0, irl};
        end
    end

    always_comb begin
        cwp_next        = cwp_reg;
        enable_next       = enable_reg;
        thresh_next       = thresh_reg;
        base_next         = base_reg;
        type_next         = type_reg;
        pc_save_next      = pc_save_reg;
        next_pc_save_next = next_pc_save_reg;
        unresumable_next  = unresumable_reg;
        error_next        = error_reg;
        queue_head_next   = queue_head_reg;
        trap_next       = '0;
        instr_go_o      = 1'b0;
        // New events set pending; set wins over the clear below
        fp_pend_next = fp_pend_reg;
        cp_pend_next = cp_pend_reg;
        mc_pend_next = mc_pend_reg;
        if (!error_reg) begin
            if (take && !enable_reg) begin
                // Trap with enable clear cannot vector; halt instead
                error_next = precise_kind || mc_pend_reg ||
                             (sel_type == TYPE_FLOAT) || (sel_type == TYPE_COPROC);
            end else if (take) begin
                type_next         = sel_type;
                cwp_next          = cwp_dec;
                pc_save_next      = instr_i.pc;
                next_pc_save_next = instr_i.next_pc;
                enable_next       = 1'b0;
                if (sel_type == TYPE_FLOAT) begin
                    fp_pend_next    = 1'b0;
                    queue_head_next = instr_i.pc;
                end
                if (sel_type == TYPE_COPROC) begin
                    cp_pend_next = 1'b0;
                end
                if (sel_type == TYPE_MCHECK) begin
                    mc_pend_next     = 1'b0;
                    unresumable_next = 1'b1;
                end
                trap_next.taken        = 1'b1;
                trap_next.trap_type    = sel_type;
                trap_next.vector       = {base_reg, sel_type, 4'h0};
                trap_next.save_pc      = instr_i.pc;
                trap_next.save_next_pc = instr_i.next_pc;
                trap_next.new_window   = cwp_dec;
            end else begin
                // Untaken lower requests stay pending for next arbitration
                instr_go_o = instr_i.valid;
            end
        end
        if (fp_ev) begin
            fp_pend_next = 1'b1;
        end
        if (cp_ev) begin
            cp_pend_next = 1'b1;
        end
        if (mc_ev) begin
            mc_pend_next = 1'b1;
        end
        // Register writes; the whole write is dropped in any cycle where take is set, for every field
        if (wb_wr && !take) begin
            unique case (wb_adr_i)
                ADDR_STATE: begin
                    cwp_next    = wb_dat_i[ST_CWP_LSB +: NWIN_BITS];
                    enable_next = wb_dat_i[ST_ENABLE_BIT];
                    thresh_next = wb_dat_i[ST_LEVEL_LSB +: 4];
                end
                ADDR_VECTOR: base_next = wb_dat_i[BASE_LSB +: 20];
                ADDR_STATUS: begin
                    // Write one clears machine-check latch and error state
                    if (wb_dat_i[1]) begin
                        unresumable_next = 1'b0;
                    end
                    if (wb_dat_i[2]) begin
                        error_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    // Bus read path and single-cycle ack
    always_comb begin
        ack_next  = wb_req;
        rdat_next = 32'h0000_0000;
        unique case (wb_adr_i)
            ADDR_STATE:    rdat_next = {20'h0_0000, thresh_reg, 2'b00, enable_reg,
                                        cwp_reg};
            ADDR_VECTOR:   rdat_next = {base_reg, type_reg, 4'h0};
            ADDR_PC_SAVE:  rdat_next = pc_save_reg;
            ADDR_NEXT_PC_SAVE: rdat_next = next_pc_save_reg;
            ADDR_STATUS:   rdat_next = {26'h000_0000, mc_pend_reg, cp_pend_reg,
                                        fp_pend_reg, error_reg, unresumable_reg,
                                        1'b0};
            ADDR_QUEUE_HEAD: rdat_next = queue_head_reg;
            default:       rdat_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cwp_reg          <= '0;
            enable_reg       <= 1'b0;
            thresh_reg       <= 4'h0;
            base_reg         <= 20'h0_0000;
            type_reg         <= 8'h00;
            pc_save_reg      <= 32'h0000_0000;
            next_pc_save_reg <= 32'h0000_0000;
            fp_pend_reg      <= 1'b0;
            cp_pend_reg      <= 1'b0;
            mc_pend_reg      <= 1'b0;
            unresumable_reg  <= 1'b0;
            error_reg        <= 1'b0;
            queue_head_reg   <= 32'h0000_0000;
            ack_reg         <= 1'b0;
            rdat_reg        <= 32'h0000_0000;
            trap_reg        <= '0;
        end else begin
            cwp_reg          <= cwp_next;
            enable_reg       <= enable_next;
            thresh_reg       <= thresh_next;
            base_reg         <= base_next;
            type_reg         <= type_next;
            pc_save_reg      <= pc_save_next;
            next_pc_save_reg <= next_pc_save_next;
            fp_pend_reg      <= fp_pend_next;
            cp_pend_reg      <= cp_pend_next;
            mc_pend_reg      <= mc_pend_next;
            unresumable_reg  <= unresumable_next;
            error_reg        <= error_next;
            queue_head_reg   <= queue_head_next;
            ack_reg         <= ack_next;
            rdat_reg        <= rdat_next;
            trap_reg        <= trap_next;
        end
    end

    assign wb_ack_o     = ack_reg;
    assign wb_dat_o     = rdat_reg;
    assign trap_o       = trap_reg;
    assign error_mode_o = error_reg;
endmodule // processor_trap_unit

//--- common/trap_pkg.sv
package trap_pkg;
    localparam int        XLEN           = 32;
    localparam int        NWIN_BITS      = 5;
    // Register offsets (word aligned byte addresses)
    localparam logic [7:0] ADDR_STATE    = 8'h00;
    localparam logic [7:0] ADDR_VECTOR   = 8'h04;
    localparam logic [7:0] ADDR_PC_SAVE  = 8'h08;
    localparam logic [7:0] ADDR_NEXT_PC_SAVE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS       = 8'h10;
    localparam logic [7:0] ADDR_QUEUE_HEAD   = 8'h14;
    // State register fields
    localparam int        ST_CWP_LSB     = 0;
    localparam int        ST_ENABLE_BIT  = 5;
    localparam int        ST_LEVEL_LSB   = 8;
    // Vector register fields
    localparam int        BASE_LSB       = 12;
    localparam int        TYPE_LSB       = 4;
    localparam logic [3:0] IRQ_UNMASKED  = 4'hF;
    // Trap type codes, hardware half below 8'h80
    localparam logic [7:0] TYPE_MCHECK    = 8'h2B;
    localparam logic [7:0] TYPE_ILLEGAL   = 8'h02;
    localparam logic [7:0] TYPE_FLOAT     = 8'h08;
    localparam logic [7:0] TYPE_COPROC    = 8'h28;
    localparam logic [7:0] TYPE_IRQ_BASE  = 8'h10;
    localparam logic [7:0] TYPE_SOFT_BASE = 8'h80;
    localparam logic [6:0] SOFT_MASK     = 7'h7F;

    typedef struct packed {
        logic       valid;
        logic       is_float;
        logic       is_coproc;
        logic       is_mc_probe;
        logic       soft_trap;
        logic [6:0] soft_num;
        logic       precise_exc;
        logic [7:0] precise_type;
        logic [XLEN-1:0] pc;
        logic [XLEN-1:0] next_pc;
    } instr_info_t;

    typedef struct packed {
        logic            taken;
        logic [7:0]      trap_type;
        logic [XLEN-1:0] vector;
        logic [XLEN-1:0] save_pc;
        logic [XLEN-1:0] save_next_pc;
        logic [NWIN_BITS-1:0] new_window;
    } trap_out_t;
endpackage

//--- tb/trap_unit_sva.sv
`timescale 1ns/1ps
module trap_unit_sva
    import trap_pkg::*;
#(
    parameter int NWINDOWS = 8
) (
    // Clock and reset
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    // Bus handshake
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_ack_o,
    // Instruction and trap results
    input wire trap_pkg::instr_info_t instr_i,
    input wire logic                  instr_go_o,
    input wire trap_pkg::trap_out_t   trap_o,
    input wire logic                  error_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus ack without a request");
    a_vector_form: assert property (
        trap_o.taken |-> trap_o.vector[11:0] == {trap_o.trap_type, 4'h0})
        else $error("vector offset does not match trap type");
    a_soft_half: assert property (
        trap_o.taken && trap_o.trap_type[7]
        |-> $past(instr_i.soft_trap) && trap_o.trap_type[6:0] == $past(instr_i.soft_num))
        else $error("upper table half used without software trap");
    a_precise_low: assert property (
        trap_o.taken && $past(instr_i.valid && instr_i.precise_exc) |-> !trap_o.trap_type[7])
        else $error("hardware trap typed in software half");
    a_saved_pc: assert property (
        trap_o.taken && $past(instr_i.valid)
        |-> trap_o.save_pc == $past(instr_i.pc)
            && trap_o.save_next_pc == $past(instr_i.next_pc))
        else $error("saved counters differ from trapped instruction");
    a_no_begin: assert property (instr_go_o |=> !trap_o.taken)
        else $error("trap taken after instruction began");
    a_trap_follows: assert property (
        instr_i.valid && !instr_go_o && !error_mode_o |=> trap_o.taken || error_mode_o)
        else $error("instruction held back without a trap");
    a_halt_quiet: assert property ($rose(error_mode_o) |-> !trap_o.taken)
        else $error("trap vectored while entering error state");
    a_window_range: assert property (trap_o.taken |-> trap_o.new_window < NWINDOWS)
        else $error("new window outside window count");
endmodule // trap_unit_sva

//--- tb/event_source.sv
`timescale 1ns/1ps
module event_source (
    // Clock and commands from the bench
    input  wire logic       clk_i,
    input  wire logic [3:0] level_i,
    input  wire logic [3:0] fire_i,
    // Pins towards the trap unit
    output logic      [3:0] irl_o,
    output logic      [3:0] event_o
);
    logic [3:0] level_reg   = 4'h0;
    logic [3:0] fire_reg    = 4'h0;
    logic [3:0] stretch_reg = 4'h0;
    // Level persists until the source withdraws it, not when a trap is taken
    always @(posedge clk_i) level_reg <= level_i;
    // Two cycles wide so the pin synchroniser cannot miss an event
    always @(posedge clk_i) fire_reg <= fire_i;
    always @(posedge clk_i) stretch_reg <= fire_reg;
    assign irl_o   = level_reg;
    assign event_o = fire_reg | stretch_reg;
endmodule // event_source

//--- tb/processor_trap_unit_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module processor_trap_unit_bench;
    import trap_pkg::*;
    localparam int         NW   = 8;
    localparam logic [19:0] BASE = 20'hA_BCDE;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0, wb_ack_o, instr_go_o, error_mode_o, go;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
    logic [3:0]  level = 4'h0, fire = 4'h0, irl, ev;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [4:0]  win = 5'h00;
    instr_info_t instr_i = '0;
    trap_out_t   trap_o, t;
    int          err_count = 0, checks_done = 0, cycles = 0;

    always #10 clk_i = ~clk_i;
    event_source far (.clk_i(clk_i), .level_i(level), .fire_i(fire), .irl_o(irl), .event_o(ev));
    processor_trap_unit #(.NWINDOWS(NW)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_i(instr_i), .instr_go_o(instr_go_o),
        .interrupt_request_level_i(irl), .float_trap_i(ev[0]), .coproc_trap_i(ev[1]),
        .mcheck_i(ev[2]), .mcheck_second_access_i(ev[3]), .trap_o(trap_o),
        .error_mode_o(error_mode_o));

    task complete_run;
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i} <= 2'b11;
        {wb_we_i, wb_adr_i, wb_dat_i} <= {w, a, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    function automatic instr_info_t ins(input logic [4:0] f, input logic [7:0] c);
        ins = '0;
        ins.valid = 1'b1;
        {ins.is_float, ins.is_coproc, ins.is_mc_probe, ins.soft_trap, ins.precise_exc} = f;
        ins.soft_num = c[6:0];
        ins.precise_type = c;
        ins.pc = {24'h00_0001, c};
        ins.next_pc = ins.pc + 32'h0000_0004;
    endfunction
    // Outputs are read before the edge's own updates land, i.e. as sampled there
    task automatic run(input instr_info_t i);
        @(posedge clk_i);
        instr_i <= i;
        @(posedge clk_i);
        go = instr_go_o;
        instr_i <= '0;
        @(posedge clk_i);
        t = trap_o;
    endtask
    task automatic arm(input logic [3:0] th, input logic e);
        wb(1'b1, ADDR_STATE, {20'h0_0000, th, 2'b00, e, win});
    endtask
    task automatic pin(input logic [3:0] l, input logic [3:0] f);
        @(posedge clk_i);
        {level, fire} <= {l, f};
        @(posedge clk_i);
        fire <= 4'h0;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic expect_go(input instr_info_t i);
        run(i);
        `CHK("go", 1'b1, go)
        `CHK("no trap", 1'b0, t.taken)
    endtask
    task automatic expect_trap(input instr_info_t i, input logic [7:0] c);
        run(i);
        `CHK("go", 1'b0, go)
        `CHK("taken", 1'b1, t.taken)
        `CHK("type", c, t.trap_type)
        `CHK("vector", {BASE, c, 4'h0}, t.vector)
        `CHK("saved pc", i.pc, t.save_pc)
        `CHK("saved next pc", i.next_pc, t.save_next_pc)
        win = 5'((win + NW - 1) % NW);
        `CHK("window", win, t.new_window)
        wb(1'b0, ADDR_STATE, 32'h0000_0000);
        `CHK("state", {1'b0, win}, q[5:0])
    endtask
    task t_precise;
        wb(1'b0, ADDR_STATE, 32'h0000_0000);
        `CHK("state reset", 32'h0000_0000, q)
        wb(1'b0, 8'h3C, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, q)
        wb(1'b1, ADDR_VECTOR, {BASE, 12'h000});
        arm(4'h0, 1'b1);
        expect_trap(ins(5'b00001, 8'h05), 8'h05);
        wb(1'b0, ADDR_VECTOR, 32'h0000_0000);
        `CHK("vector reg", {BASE, 8'h05, 4'h0}, q)
        // A write without all byte lanes must leave the table base alone
        wb_sel_i <= 4'h3;
        wb(1'b1, ADDR_VECTOR, 32'h0000_0000);
        wb_sel_i <= 4'hF;
        wb(1'b0, ADDR_VECTOR, 32'h0000_0000);
        `CHK("partial write", {BASE, 8'h05, 4'h0}, q)
        wb(1'b0, ADDR_PC_SAVE, 32'h0000_0000);
        `CHK("pc reg", 32'h0000_0105, q)
        arm(4'h0, 1'b1);
        expect_trap(ins(5'b00011, 8'h06), 8'h06);
        arm(4'h0, 1'b1);
        expect_trap(ins(5'b00010, 8'h7F), 8'hFF);
        arm(4'h0, 1'b1);
        expect_trap(ins(5'b00010, 8'h00), 8'h80);
    endtask
    task t_irq;
        pin(4'h5, 4'h0);
        arm(4'h5, 1'b1);
        expect_go(ins(5'b00000, 8'h00));
        pin(4'h6, 4'h0);
        expect_trap(ins(5'b00001, 8'h07), 8'h07);
        arm(4'h5, 1'b1);
        expect_trap(ins(5'b00000, 8'h00), 8'h16);
        pin(4'hF, 4'h0);
        arm(4'hF, 1'b1);
        expect_trap(ins(5'b00000, 8'h01), 8'h1F);
        arm(4'hF, 1'b0);
        expect_go(ins(5'b00000, 8'h02));
        pin(4'h0, 4'h0);
    endtask
    task t_defer;
        arm(4'h0, 1'b1);
        pin(4'h0, 4'b0001);
        expect_go(ins(5'b01000, 8'h00));
        expect_trap(ins(5'b00001, 8'h03), 8'h03);
        arm(4'h0, 1'b1);
        expect_trap(ins(5'b10000, 8'h00), TYPE_FLOAT);
        wb(1'b0, ADDR_QUEUE_HEAD, 32'h0000_0000);
        `CHK("queue head", 32'h0000_0100, q)
        arm(4'h0, 1'b1);
        pin(4'h0, 4'b0010);
        expect_go(ins(5'b10000, 8'h01));
        expect_trap(ins(5'b01000, 8'h01), TYPE_COPROC);
        arm(4'h0, 1'b1);
        pin(4'h0, 4'b0100);
        expect_trap(ins(5'b00001, 8'h02), TYPE_MCHECK);
        wb(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK("unresumable", 1'b1, q[1])
        wb(1'b1, ADDR_STATUS, 32'h0000_0002);
        // Second-access check traps with no instruction waiting
        arm(4'h0, 1'b1);
        pin(4'h0, 4'b1100);
        win = 5'((win + NW - 1) % NW);
        wb(1'b0, ADDR_VECTOR, 32'h0000_0000);
        `CHK("second access", TYPE_MCHECK, q[11:4])
        wb(1'b0, ADDR_STATE, 32'h0000_0000);
        `CHK("second state", {1'b0, win}, q[5:0])
    endtask
    task t_halt;
        arm(4'h0, 1'b0);
        run(ins(5'b00001, 8'h04));
        `CHK("halt no trap", 1'b0, t.taken)
        `CHK("halted", 1'b1, error_mode_o)
        wb(1'b1, ADDR_STATUS, 32'h0000_0004);
        wb(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK("error cleared", 1'b0, q[2])
        `CHK("running", 1'b0, error_mode_o)
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_precise();
        t_irq();
        t_defer();
        t_halt();
        complete_run();
    end
endmodule // processor_trap_unit_bench

bind processor_trap_unit trap_unit_sva #(.NWINDOWS(NWINDOWS)) sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .instr_i(instr_i), .instr_go_o(instr_go_o),
    .trap_o(trap_o), .error_mode_o(error_mode_o));
